// File: logic/sleep_clk_pkg.sv
// Purpose: shared constants for the sleep clock gating and power flag block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets are byte addresses
package sleep_clk_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W               = 8;
  localparam int          DATA_W               = 32;
  localparam logic [7:0]  OFF_CLOCK_SELECT_TWO = 8'h1C;
  localparam logic [7:0]  OFF_SLEEP_ENABLES    = 8'h20;
  localparam logic [7:0]  OFF_POWER_FLAGS      = 8'h24;
  localparam logic [7:0]  OFF_INT_STATUS       = 8'h30;
  localparam logic [7:0]  OFF_INT_CLEAR        = 8'h34;
  localparam logic [7:0]  OFF_INT_ENABLE       = 8'h38;

  // ----------------------------------------------------------------
  // clock_select_two fields
  // ----------------------------------------------------------------
  localparam int          DIV_LSB              = 8;
  localparam int          DIV_W                = 4;
  localparam int          AUDIO_SEL_LSB        = 0;
  localparam int          AUDIO_SEL_W          = 2;
  localparam logic [3:0]  DIV_RESET            = 4'h0;

  typedef enum logic [1:0] {
    AUDIO_SRC_SLOW_OSC = 2'h0,
    AUDIO_SRC_CRYSTAL  = 2'h1,
    AUDIO_SRC_BUS      = 2'h2,
    AUDIO_SRC_FAST     = 2'h3
  } audio_src_t;

  // ----------------------------------------------------------------
  // sleep_clock_enables bit positions
  // ----------------------------------------------------------------
  localparam int ANALOG_SLEEP_GATE         = 30;
  localparam int AUDIO_SERIAL_SLEEP_GATE   = 29;
  localparam int SIGMA_DELTA_SLEEP_GATE    = 28;
  localparam int PULSE_PAIR_HI_SLEEP_GATE  = 21;
  localparam int PULSE_PAIR_LO_SLEEP_GATE  = 20;
  localparam int FILTER_LEVEL_SLEEP_GATE   = 18;
  localparam int SAR_CONVERTER_SLEEP_GATE  = 17;
  localparam int FIRST_SERIAL_SLEEP_GATE   = 16;
  localparam int SECOND_SERIAL_SLEEP_GATE  = 15;
  localparam int SPEAKER_DRIVER_SLEEP_GATE = 13;
  localparam int SPI_A_SLEEP_GATE          = 12;
  localparam int SPI_B_SLEEP_GATE          = 11;
  localparam int TWO_WIRE_SLEEP_GATE       = 8;
  localparam int TIMER_B_SLEEP_GATE        = 7;
  localparam int TIMER_A_SLEEP_GATE        = 6;
  localparam int CALENDAR_SLEEP_GATE       = 5;
  localparam int WATCHDOG_SLEEP_GATE       = 4;
  localparam int FLASH_PROG_SLEEP_GATE     = 2;
  localparam int DMA_SLEEP_GATE            = 1;
  localparam int CPU_BUS_SLEEP_GATE        = 0;

  localparam logic [31:0] SLEEP_VALID_MASK =
    (32'h1 << ANALOG_SLEEP_GATE) | (32'h1 << AUDIO_SERIAL_SLEEP_GATE) | (32'h1 << SIGMA_DELTA_SLEEP_GATE) |
    (32'h1 << PULSE_PAIR_HI_SLEEP_GATE) | (32'h1 << PULSE_PAIR_LO_SLEEP_GATE) |
    (32'h1 << FILTER_LEVEL_SLEEP_GATE) | (32'h1 << SAR_CONVERTER_SLEEP_GATE) |
    (32'h1 << FIRST_SERIAL_SLEEP_GATE) | (32'h1 << SECOND_SERIAL_SLEEP_GATE) |
    (32'h1 << SPEAKER_DRIVER_SLEEP_GATE) | (32'h1 << SPI_A_SLEEP_GATE) | (32'h1 << SPI_B_SLEEP_GATE) |
    (32'h1 << TWO_WIRE_SLEEP_GATE) | (32'h1 << TIMER_B_SLEEP_GATE) | (32'h1 << TIMER_A_SLEEP_GATE) |
    (32'h1 << CALENDAR_SLEEP_GATE) | (32'h1 << WATCHDOG_SLEEP_GATE) | (32'h1 << FLASH_PROG_SLEEP_GATE) |
    (32'h1 << DMA_SLEEP_GATE) | (32'h1 << CPU_BUS_SLEEP_GATE);
  localparam logic [31:0] SLEEP_RESET      = 32'h0FFF_FFFF & SLEEP_VALID_MASK;

  // ----------------------------------------------------------------
  // power_state_flags and interrupt layout
  // ----------------------------------------------------------------
  localparam int          FLAG_W           = 3;
  localparam int          STANDBY_FLAG     = 2;
  localparam int          HALTED_FLAG      = 1;
  localparam int          DEEP_SLEEP_FLAG  = 0;
  localparam logic [2:0]  FLAGS_RESET      = 3'h0;

endpackage : sleep_clk_pkg

// File: logic/clk_cfg_if.sv
// Purpose: carrier between the register core and its gating and divider helpers
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface clk_cfg_if;
  logic [31:0] sleep_en;
  logic [31:0] run_en;
  logic        cpu_sleep;
  logic [31:0] gates;
  logic [3:0]  div;
  logic        src_tick;
  logic        out_tick;

  modport ctl     (output sleep_en, run_en, cpu_sleep, div, src_tick, input gates, out_tick);
  modport gate    (input sleep_en, run_en, cpu_sleep, output gates);
  modport divider (input div, src_tick, output out_tick);
endinterface : clk_cfg_if

// File: logic/sleep_gate.sv
// Purpose: per-peripheral clock enables for run and sleep
// Assumes: run enables share the sleep register layout
// Notes:   gates are registered
`timescale 1ns/1ps
module sleep_gate
  import sleep_clk_pkg::*;
(
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_n_i,    // sync reset, active low
  clk_cfg_if.gate   cfg         // enables in, gates out
);
  typedef struct packed {
    logic [31:0] gates;
  } gate_state_t;

  gate_state_t r;
  gate_state_t next_r;

  always_comb begin
    next_r       = r;
    // awake: run enable alone; asleep: run enable and sleep enable
    next_r.gates = cfg.run_en & (~{32{cfg.cpu_sleep}} | cfg.sleep_en) & SLEEP_VALID_MASK;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cfg.gates = r.gates;
endmodule : sleep_gate

// File: logic/tick_divider.sv
// Purpose: divides a source tick stream by (div + 1)
// Assumes: source ticks are one-cycle pulses
// Notes:   a new divide value applies at once; at or below the count it wraps on the next source tick
`timescale 1ns/1ps
module tick_divider
  import sleep_clk_pkg::*;
(
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_n_i,    // sync reset, active low
  clk_cfg_if.divider cfg        // divide value and ticks
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } div_state_t;

  div_state_t r;
  div_state_t next_r;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (cfg.src_tick) begin
      if (r.cnt >= cfg.div) begin
        next_r.cnt  = '0;
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = DIV_W'(r.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cfg.out_tick = r.tick;
endmodule : tick_divider

// File: logic/sleep_clock_ctrl.sv
// Purpose: sleep clock gating, second serial divider, audio clock select, power flags
// Assumes: apb slave, zero wait states, 100 MHz sys_clk_i
// Notes:   power-state events also raise a maskable interrupt
//
// Contract
// - second serial clock is the serial source divided by divider plus one
// - audio select: 00 slow osc (reset), 01 crystal, 10 bus, 11 fast osc
// - asleep, a clock runs only if run enable and sleep enable are both one
// - bits 30, 29, 28 gate analog, audio serial and sigma-delta clocks in sleep
// - bit 21 gates pulse channels two/three, bit 20 channels zero/one
// - bits 18..15 gate filter, sar converter, first and second serial port
// - bits 13, 12, 11, 8 gate speaker driver, two spi, two-wire; 10, 9 reserved
// - bits 7..4 gate timer one, timer zero, calendar and watchdog in sleep
// - bit 2 gates flash programming clock, bit 1 the dma clock in sleep
// - standby flag bit 2 sets on standby entry, write one clears
// - halted flag bit 1 sets on stop without power down, write one clears
// - deep sleep flag bit 0 sets on deep sleep, write one clears, zero ignored
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module sleep_clock_ctrl (
  input  wire logic                               sys_clk_i,            // system clock, 100 MHz
  input  wire logic                               rst_n_i,              // sync reset, active low
  input  wire logic                               psel_i,               // apb select
  input  wire logic                               penable_i,            // apb enable
  input  wire logic                               pwrite_i,             // apb write
  input  wire logic [sleep_clk_pkg::ADDR_W-1:0]   paddr_i,              // apb byte address
  input  wire logic [sleep_clk_pkg::DATA_W-1:0]   pwdata_i,             // apb write data
  output logic      [sleep_clk_pkg::DATA_W-1:0]   prdata_o,             // apb read data
  output logic                                    pready_o,             // apb ready
  output logic                                    pslverr_o,            // apb error, unmapped address
  input  wire logic [31:0]                        run_enables_i,        // run-mode enables, sleep layout
  input  wire logic                               cpu_sleep_i,          // cpu is in sleep
  input  wire logic                               serial_src_tick_i,    // serial source clock tick
  input  wire logic [3:0]                         audio_src_i,          // audio source clocks by code
  input  wire logic                               standby_entry_i,      // pulse: entered standby
  input  wire logic                               halted_entry_i,       // pulse: stopped, powered
  input  wire logic                               deep_sleep_entry_i,   // pulse: entered deep sleep
  output logic      [31:0]                        clock_gates_o,        // per-peripheral clock enables
  output logic                                    second_serial_tick_o, // divided serial tick
  output logic                                    audio_clk_o,          // selected audio clock
  output logic      [sleep_clk_pkg::AUDIO_SEL_W-1:0] audio_clk_sel_o,   // audio select field
  output logic                                    irq_o                 // interrupt, active high
);
  import sleep_clk_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0]       div;
    audio_src_t             audio_sel;
    logic [31:0]            sleep_en;
    logic [FLAG_W-1:0]      flags;
    logic [FLAG_W-1:0]      int_status;
    logic [FLAG_W-1:0]      int_enable;
    logic [DATA_W-1:0]      rdata;
    logic                   ready;
    logic                   slverr;
    logic                   irq;
    logic                   audio_clk;
  } ctrl_state_t;

  ctrl_state_t r;
  ctrl_state_t next_r;
  clk_cfg_if   cfg ();

  logic              setup;
  logic              wr_done;
  logic [FLAG_W-1:0] events;
  logic [FLAG_W-1:0] flag_clr;
  logic [FLAG_W-1:0] int_clr;
  logic [DATA_W-1:0] rd_val;
  logic              hit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  sleep_gate u_gate (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .cfg       (cfg.gate)
  );

  tick_divider u_div (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .cfg       (cfg.divider)
  );

  assign cfg.sleep_en  = r.sleep_en;
  assign cfg.run_en    = run_enables_i;
  assign cfg.cpu_sleep = cpu_sleep_i;
  assign cfg.div       = r.div;
  assign cfg.src_tick  = serial_src_tick_i;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup   = psel_i & ~penable_i;
  assign wr_done = psel_i & penable_i & r.ready & pwrite_i & ~r.slverr;

  always_comb begin
    events                  = '0;
    events[STANDBY_FLAG]    = standby_entry_i;
    events[HALTED_FLAG]     = halted_entry_i;
    events[DEEP_SLEEP_FLAG] = deep_sleep_entry_i;
  end

  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (paddr_i)
      OFF_CLOCK_SELECT_TWO: begin
        rd_val[DIV_LSB +: DIV_W]             = r.div;
        rd_val[AUDIO_SEL_LSB +: AUDIO_SEL_W] = r.audio_sel;
      end
      OFF_SLEEP_ENABLES: begin
        rd_val = r.sleep_en & SLEEP_VALID_MASK;
      end
      OFF_POWER_FLAGS: begin
        rd_val[FLAG_W-1:0] = r.flags;
      end
      OFF_INT_STATUS: begin
        rd_val[FLAG_W-1:0] = r.int_status;
      end
      OFF_INT_CLEAR: begin
        rd_val = '0;
      end
      OFF_INT_ENABLE: begin
        rd_val[FLAG_W-1:0] = r.int_enable;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // write-one-to-clear strobes, only the low flag bits are looked at
  always_comb begin
    flag_clr = '0;
    int_clr  = '0;
    if (wr_done && paddr_i == OFF_POWER_FLAGS) begin
      flag_clr = pwdata_i[FLAG_W-1:0];
    end
    if (wr_done && paddr_i == OFF_INT_CLEAR) begin
      int_clr = pwdata_i[FLAG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.ready  = 1'b0;
    next_r.slverr = 1'b0;

    // answer one cycle after setup: zero wait states
    if (setup) begin
      next_r.ready  = 1'b1;
      next_r.slverr = ~hit;
      next_r.rdata  = hit ? rd_val : '0;
    end

    if (wr_done) begin
      unique case (paddr_i)
        OFF_CLOCK_SELECT_TWO: begin
          // reserved bits of this word are simply not stored
          next_r.div       = pwdata_i[DIV_LSB +: DIV_W];
          next_r.audio_sel = audio_src_t'(pwdata_i[AUDIO_SEL_LSB +: AUDIO_SEL_W]);
        end
        OFF_SLEEP_ENABLES: begin
          // gates for bits 30..28, 21..20, 18..15, 13..11, 8, 7..4, 2..0
          next_r.sleep_en = pwdata_i & SLEEP_VALID_MASK;
        end
        OFF_INT_ENABLE: begin
          next_r.int_enable = pwdata_i[FLAG_W-1:0];
        end
        default: begin
          next_r.div = r.div;
        end
      endcase
    end

    // a flag raised in the same cycle as its clear stays set
    next_r.flags      = (r.flags & ~flag_clr) | events;
    next_r.int_status = (r.int_status & ~int_clr) | events;
    next_r.irq        = |(next_r.int_status & next_r.int_enable);

    // audio clock follows the selected source
    next_r.audio_clk = audio_src_i[r.audio_sel];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r            <= '0;
      r.div        <= DIV_RESET;
      r.audio_sel  <= AUDIO_SRC_SLOW_OSC;
      r.sleep_en   <= SLEEP_RESET;
      r.flags      <= FLAGS_RESET;
      r.int_status <= FLAGS_RESET;
      r.int_enable <= FLAGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o             = r.rdata;
  assign pready_o             = r.ready;
  assign pslverr_o            = r.slverr;
  assign irq_o                = r.irq;
  assign audio_clk_o          = r.audio_clk;
  assign audio_clk_sel_o      = r.audio_sel;
  assign clock_gates_o        = cfg.gates;
  assign second_serial_tick_o = cfg.out_tick;

endmodule : sleep_clock_ctrl

// File: verif/sleep_clock_ctrl_asserts.sv
// Purpose: port-level assertions for sleep_clock_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top
`timescale 1ns/1ps
module sleep_clock_ctrl_asserts
  import sleep_clk_pkg::*;
(
  input wire logic              sys_clk_i,            // clock
  input wire logic              rst_n_i,              // reset
  input wire logic              psel_i,               // select
  input wire logic              penable_i,            // enable
  input wire logic              pwrite_i,             // write
  input wire logic [ADDR_W-1:0] paddr_i,              // address
  input wire logic [DATA_W-1:0] prdata_o,             // read data
  input wire logic              pready_o,             // ready
  input wire logic              pslverr_o,            // error
  input wire logic [31:0]       run_enables_i,        // run enables
  input wire logic              cpu_sleep_i,          // asleep
  input wire logic              serial_src_tick_i,    // source tick
  input wire logic [3:0]        audio_src_i,          // audio sources
  input wire logic [31:0]       clock_gates_o,        // gates
  input wire logic              second_serial_tick_o, // divided tick
  input wire logic              audio_clk_o,          // audio clock
  input wire logic [1:0]        audio_clk_sel_o       // audio select
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  wire  setup  = psel_i && !penable_i;
  wire  acc_rd = psel_i && penable_i && pready_o && !pwrite_i;
  wire  mapped = paddr_i inside {OFF_CLOCK_SELECT_TWO, OFF_SLEEP_ENABLES, OFF_POWER_FLAGS,
                                 OFF_INT_STATUS, OFF_INT_CLEAR, OFF_INT_ENABLE};
  wire  audio_pick = audio_src_i[audio_clk_sel_o];

  a_ready_after_setup: assert property (rst_n_i && setup |=> pready_o)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (rst_n_i && setup && !mapped |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_gate_awake: assert property (rst_n_i && !cpu_sleep_i |=> clock_gates_o == ($past(run_enables_i) & SLEEP_VALID_MASK))
    else $error("awake gates differ from run enables");
  a_gate_sleep: assert property (rst_n_i && cpu_sleep_i |=> (clock_gates_o & ~$past(run_enables_i)) == 32'h0)
    else $error("sleep gate open without run enable");
  a_gate_reserved: assert property ((clock_gates_o & ~32'h7037_B9F7) == 32'h0)
    else $error("reserved gate bit set");
  a_audio_follow: assert property (rst_n_i && $stable(audio_clk_sel_o) |=> audio_clk_o == $past(audio_pick))
    else $error("audio clock not the selected source");
  a_tick_source: assert property (second_serial_tick_o |-> $past(serial_src_tick_i))
    else $error("divided tick without source tick");
  a_flags_reserved: assert property (acc_rd && paddr_i == OFF_POWER_FLAGS |-> prdata_o[31:3] == 29'h0)
    else $error("flag reserved bits not zero");
  a_sel_reserved: assert property (acc_rd && paddr_i == OFF_CLOCK_SELECT_TWO |-> (prdata_o & ~32'hF03) == 32'h0)
    else $error("select reserved bits not zero");

  c_refused: cover property (pslverr_o);
  c_sleep_gate: cover property (cpu_sleep_i && clock_gates_o != 32'h0);
  c_tick: cover property (second_serial_tick_o);
endmodule : sleep_clock_ctrl_asserts

// File: verif/tb_sleep_clock_ctrl.sv
// Purpose: self-checking bench for sleep_clock_ctrl
// Assumes: zero-wait apb slave, 100 MHz clock
// Notes:   reads queue their expectation, a monitor compares
`timescale 1ns/1ps
module tb_sleep_clock_ctrl;
  import sleep_clk_pkg::*;
  localparam logic [31:0] GATE_BITS = 32'h7037_B9F7;
  logic        sys_clk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic        cpu_sleep_i = 1'h0, serial_src_tick_i = 1'h0;
  logic [7:0]  paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0, run_enables_i = 32'h0, prdata_o, clock_gates_o;
  logic [3:0]  audio_src_i = 4'h0;
  logic [2:0]  ev = 3'h0;
  logic        pready_o, pslverr_o, second_serial_tick_o, audio_clk_o, irq_o;
  logic [1:0]  audio_clk_sel_o;
  logic [32:0] expq[$];
  int          fails = 0, n_tests = 0, cyc = 0, pulses = 0;

  sleep_clock_ctrl i_sleep_clock_ctrl (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .run_enables_i, .cpu_sleep_i, .serial_src_tick_i,
    .audio_src_i, .standby_entry_i(ev[2]), .halted_entry_i(ev[1]), .deep_sleep_entry_i(ev[0]),
    .clock_gates_o, .second_serial_tick_o, .audio_clk_o, .audio_clk_sel_o, .irq_o);

  always #5 sys_clk_i = ~sys_clk_i;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // leaves the bus in access phase so a setup may follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    if (!w) expq.push_back(e);
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    // only the bench timeout ends a wait for ready
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'h1);
  endtask : apb

  task automatic idle;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge sys_clk_i);
  endtask : idle

  task automatic pulse(input logic [2:0] b);
    ev <= b;
    @(posedge sys_clk_i);
    ev <= 3'h0;
    @(posedge sys_clk_i);
  endtask : pulse

  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (psel_i && penable_i && pready_o && !pwrite_i)
      chk({pslverr_o, prdata_o}, expq.size() > 0 ? expq.pop_front() : 33'hX);
    if (second_serial_tick_o) pulses++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] w;
    logic [3:0]  d;
    logic [2:0]  b;
    int          p0;
    void'($urandom(32'hEE14C872));
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    @(posedge sys_clk_i);
    apb(1'h0, OFF_CLOCK_SELECT_TWO, 32'h0, 33'h0);
    apb(1'h0, OFF_SLEEP_ENABLES, 32'h0, {1'h0, 32'h0FFF_FFFF & GATE_BITS});
    apb(1'h0, OFF_POWER_FLAGS, 32'h0, 33'h0);
    apb(1'h1, 8'h2C, 32'hFFFF_FFFF, 33'h0);
    apb(1'h0, 8'h2C, 32'h0, {1'h1, 32'h0});
    apb(1'h1, OFF_SLEEP_ENABLES, 32'hFFFF_FFFF, 33'h0);
    apb(1'h0, OFF_SLEEP_ENABLES, 32'h0, {1'h0, GATE_BITS});
    for (int i = 0; i < 8; i++) begin
      w = $urandom() | 32'h1;
      apb(1'h1, OFF_SLEEP_ENABLES, w, 33'h0);
      apb(1'h0, OFF_SLEEP_ENABLES, 32'h0, {1'h0, w & GATE_BITS});
      idle;
      run_enables_i <= $urandom();
      cpu_sleep_i <= i[0];
      repeat (2) @(posedge sys_clk_i);
      chk({1'h0, clock_gates_o}, {1'h0, run_enables_i & GATE_BITS & (cpu_sleep_i ? w : 32'hFFFF_FFFF)});
    end
    cpu_sleep_i <= 1'h0;
    for (int c = 0; c < 4; c++) begin
      d = (c == 3) ? 4'hF : (c == 2) ? 4'($urandom_range(14, 2)) : c[3:0];
      // sources are changed after the select is written and read back
      apb(1'h1, OFF_CLOCK_SELECT_TWO, {20'hFFFFF, d, 6'h3F, c[1:0]}, 33'h0);
      apb(1'h0, OFF_CLOCK_SELECT_TWO, 32'h0, {21'h0, d, 6'h0, c[1:0]});
      idle;
      audio_src_i <= 4'($urandom());
      repeat (2) @(posedge sys_clk_i);
      chk({31'h0, audio_clk_sel_o}, {31'h0, c[1:0]});
      chk({32'h0, audio_clk_o}, {32'h0, audio_src_i[c[1:0]]});
      p0 = pulses;
      repeat (3 * (int'(d) + 1)) begin
        serial_src_tick_i <= 1'h1;
        @(posedge sys_clk_i);
        serial_src_tick_i <= 1'h0;
        @(posedge sys_clk_i);
      end
      repeat (3) @(posedge sys_clk_i);
      chk(33'(pulses - p0), 33'h3);
    end
    apb(1'h1, OFF_INT_ENABLE, 32'h7, 33'h0);
    for (int k = 0; k < 4; k++) begin
      b = 3'(1 << (k % 3));
      if (k == 3) apb(1'h1, OFF_INT_ENABLE, 32'h0, 33'h0);
      idle;
      pulse(b);
      chk({32'h0, irq_o}, {32'h0, k < 3});
      apb(1'h1, OFF_POWER_FLAGS, ~{29'h0, b}, 33'h0);
      apb(1'h0, OFF_POWER_FLAGS, 32'h0, {30'h0, b});
      apb(1'h0, OFF_INT_STATUS, 32'h0, {30'h0, b});
      apb(1'h1, OFF_POWER_FLAGS, {29'h0, b}, 33'h0);
      apb(1'h1, OFF_INT_CLEAR, {29'h0, b}, 33'h0);
      apb(1'h0, OFF_POWER_FLAGS, 32'h0, 33'h0);
      idle;
      chk({32'h0, irq_o}, 33'h0);
    end
    repeat (2) @(posedge sys_clk_i);
    finish_test;
  end
endmodule : tb_sleep_clock_ctrl

bind sleep_clock_ctrl sleep_clock_ctrl_asserts i_sleep_clock_ctrl_asserts (.sys_clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .run_enables_i, .cpu_sleep_i,
  .serial_src_tick_i, .audio_src_i, .clock_gates_o, .second_serial_tick_o, .audio_clk_o, .audio_clk_sel_o);
